// >>> hdl/cps_regs.vh
// constants for the codec clock and power sequencing controller
`ifndef CPS_REGS_VH
`define CPS_REGS_VH

// system clock rate
`define CPS_CLK_HZ          100000000
`define CPS_CLK_PER_MS      100000

// timing figures, in milliseconds unless named otherwise
`define CPS_T_RESET_MS      10
`define CPS_T_SETTLE_MS     1
`define CPS_T_LOCK_MASTER_MS 4
`define CPS_T_LOCK_FRAME_MS 40
`define CPS_T_LOCK_BIT_MS   4
`define CPS_T_OSC_MS        1
`define CPS_LIMIT_PERIODS   1059
`define CPS_FS_HZ           44100

// clocking modes
`define CPS_MODE_PLL_MASTER 2'h0
`define CPS_MODE_PLL_SLAVE  2'h1
`define CPS_MODE_EXT_SLAVE  2'h2
`define CPS_MODE_EXT_MASTER 2'h3

// device control register holding the clock enables
`define CPS_ADDR_CLOCK      8'h01
`define CPS_BIT_OSC_EN      0
`define CPS_BIT_PLL_EN      1
`define CPS_BIT_MASTER_SEL  3

// device control register holding the four block power bits
`define CPS_ADDR_POWER      8'h00
`define CPS_BIT_ADC_PWR     0
`define CPS_BIT_DSP_PWR     1
`define CPS_BIT_LOA_PWR     2
`define CPS_BIT_LOB_PWR     3

// device register ranges the configuration table is expected to cover
`define CPS_ADDR_VOL_FIRST  8'h05
`define CPS_ADDR_VOL_LAST   8'h06
`define CPS_ADDR_LIM1_FIRST 8'h08
`define CPS_ADDR_LIM1_REF   8'h0A
`define CPS_ADDR_LIM2_FIRST 8'h0B
`define CPS_ADDR_LIM2_REF   8'h0D
`define CPS_ADDR_F1_FIRST   8'h0E
`define CPS_ADDR_F1_LAST    8'h17
`define CPS_ADDR_EQ1_FIRST  8'h18
`define CPS_ADDR_EQ1_LAST   8'h45
`define CPS_ADDR_F2_FIRST   8'h46
`define CPS_ADDR_F2_LAST    8'h4F
`define CPS_ADDR_EQ2_FIRST  8'h50
`define CPS_ADDR_EQ2_LAST   8'h7D

// configuration table shape
`define CPS_TBL_AW          7
`define CPS_TBL_DEPTH       128
`define CPS_TBL_DW          16

`endif

// >>> hdl/cps_cfg_mem.v
// configuration table memory: address/data pairs, registered read
`timescale 1ns/1ns
`default_nettype none
`include "cps_regs.vh"

module cps_cfg_mem (
	// clock
	input  wire                      sys_clk,
	// write side
	input  wire                      wrEn,
	input  wire [`CPS_TBL_AW-1:0]    wrIdx,
	input  wire [`CPS_TBL_DW-1:0]    wrWord,
	// read side
	input  wire [`CPS_TBL_AW-1:0]    rdIdx,
	output reg  [`CPS_TBL_DW-1:0]    rdWord
);

	reg [`CPS_TBL_DW-1:0] mem [0:`CPS_TBL_DEPTH-1];

	always @(posedge sys_clk) begin
		if (wrEn) begin
			mem[wrIdx] <= wrWord;
		end
		rdWord <= mem[rdIdx];
	end

endmodule // cps_cfg_mem
`default_nettype wire

// >>> hdl/cps_sequencer.v
// host-side start-up, clock and power sequencer for the audio codec
// Codec rules this block works to
// RULE1 - hold the reset pin low at least 10 ms before raising it
// RULE2 - no register writes during the 1 ms reference power-up after reset
// RULE3 - PLL master: write format and rate fields before oscillator and PLL enable
// RULE4 - after enabling oscillator and PLL, allow 4 ms for lock
// RULE5 - PLL master: device clocks appear only after lock; wait before use
// RULE6 - PLL slave lock: 40 ms on frame clock, 4 ms on bit clock
// RULE7 - PLL slave: write fields, then supply the reference clocks
// RULE8 - external slave: write fields, then supply master, frame and bit clocks (here the master clock starts at end of settle, before the fields)
// RULE9 - external master: master-select set only after master clock is stable
// RULE10 - PLL mode: after a rate change wait lock time before power-up
// RULE11 - 2.1 path settings come from the loaded configuration table
// RULE12 - device ramps volume softly after power-up; nothing to drive here
// RULE13 - limiter settings written from the table before power-up
// RULE14 - first DSP coefficients written from the table before power-up
// RULE15 - second DSP coefficients written from the table before power-up
// RULE16 - all four power bits set together, and cleared together
// RULE17 - running reported only after 1059 sample periods of limiter start-up
// RULE18 - PLL master stop: clear oscillator and PLL bits, then stop master clock
// RULE19 - PLL slave stop: clear PLL bit, then stop bit and frame clocks
// RULE20 - external master stop: device parks its clocks once master clock stops
// RULE21 - driving the reset pin low returns device registers to defaults
// RULE22 - clocks are supplied whenever any device block is powered
`timescale 1ns/1ns
`default_nettype none
`include "cps_regs.vh"

module cps_sequencer #(
	parameter [31:0] RESET_CYC  = `CPS_T_RESET_MS * `CPS_CLK_PER_MS,
	parameter [31:0] SETTLE_CYC = `CPS_T_SETTLE_MS * `CPS_CLK_PER_MS,
	parameter [31:0] LOCK_M_CYC = `CPS_T_LOCK_MASTER_MS * `CPS_CLK_PER_MS,
	parameter [31:0] LOCK_F_CYC = `CPS_T_LOCK_FRAME_MS * `CPS_CLK_PER_MS,
	parameter [31:0] LOCK_B_CYC = `CPS_T_LOCK_BIT_MS * `CPS_CLK_PER_MS,
	parameter [31:0] OSC_CYC    = `CPS_T_OSC_MS * `CPS_CLK_PER_MS,
	parameter [31:0] LIMIT_CYC  = (`CPS_LIMIT_PERIODS * (`CPS_CLK_HZ / 100)
		+ (`CPS_FS_HZ / 100) - 1) / (`CPS_FS_HZ / 100)
) (
	// clock and reset
	input  wire                      sys_clk,
	input  wire                      srst,
	// user commands, one-cycle pulses
	input  wire                      cmdStart,
	input  wire                      cmdReconfig,
	input  wire                      cmdPowerUp,
	input  wire                      cmdPowerDown,
	input  wire                      cmdStop,
	// user configuration
	input  wire [1:0]                clockMode,
	input  wire                      pllRefIsFrame,
	input  wire [`CPS_TBL_AW:0]      tblCount,
	// configuration table load port
	input  wire                      tblWrEn,
	input  wire [`CPS_TBL_AW-1:0]    tblWrIdx,
	input  wire [7:0]                tblWrAddr,
	input  wire [7:0]                tblWrData,
	// device register write requests, to the control-port engine
	output reg                       regWrValid,
	output reg  [7:0]                regWrAddr,
	output reg  [7:0]                regWrData,
	input  wire                      regWrReady,
	// device pins and host clock sources
	output reg                       powerDownResetPinN,
	output reg                       masterClockRun,
	output reg                       linkClocksRun,
	// status
	output wire                      statusOff,
	output wire                      statusClockReady,
	output wire                      statusRunning,
	output wire                      statusBusy
);

	localparam [11:0] S_OFF    = 12'h001;
	localparam [11:0] S_RST    = 12'h002;
	localparam [11:0] S_SETTLE = 12'h004;
	localparam [11:0] S_CFG    = 12'h008;
	localparam [11:0] S_PRE    = 12'h010;
	localparam [11:0] S_CLKW   = 12'h020;
	localparam [11:0] S_LOCK   = 12'h040;
	localparam [11:0] S_READY  = 12'h080;
	localparam [11:0] S_PWRW   = 12'h100;
	localparam [11:0] S_LIMIT  = 12'h200;
	localparam [11:0] S_RUN    = 12'h400;
	localparam [11:0] S_STOPW  = 12'h800;

	localparam [7:0] CLK_OSC_PLL = 8'h03;
	localparam [7:0] CLK_MASTER  = 8'h09;
	localparam [7:0] PWR_ALL     = 8'h0F;
	localparam [7:0] ZERO_BYTE   = 8'h00;

	reg  [11:0]              state;
	reg  [31:0]              cnt;
	reg  [`CPS_TBL_AW:0]     idx;
	reg                      rdPend;
	reg                      clkUp;
	reg                      pwrOn;
	wire [`CPS_TBL_DW-1:0]   tblWord;
	wire                     wrDone;
	wire [31:0]              lockCyc;

	function isPll;
		input [1:0] mode;
		begin
			isPll = (mode == `CPS_MODE_PLL_MASTER) || (mode == `CPS_MODE_PLL_SLAVE);
		end
	endfunction

	cps_cfg_mem uTable (
		.sys_clk (sys_clk),
		.wrEn    (tblWrEn),
		.wrIdx   (tblWrIdx),
		.wrWord  ({tblWrAddr, tblWrData}),
		.rdIdx   (idx[`CPS_TBL_AW-1:0]),
		.rdWord  (tblWord)
	);

	assign wrDone  = regWrValid && regWrReady;
	// RULE6 lock by reference
	assign lockCyc = (clockMode == `CPS_MODE_PLL_SLAVE) ?
		(pllRefIsFrame ? LOCK_F_CYC : LOCK_B_CYC) : LOCK_M_CYC;

	assign statusOff        = state[0];
	assign statusClockReady = state[7];
	assign statusRunning    = state[10];
	assign statusBusy       = ~(state[0] | state[7] | state[10]);

	always @(posedge sys_clk) begin
		if (srst) begin
			state              <= S_OFF;
			cnt                <= 32'h0;
			idx                <= {(`CPS_TBL_AW+1){1'b0}};
			rdPend             <= 1'b0;
			clkUp              <= 1'b0;
			pwrOn              <= 1'b0;
			regWrValid         <= 1'b0;
			regWrAddr          <= 8'h00;
			regWrData          <= 8'h00;
			powerDownResetPinN <= 1'b0;
			masterClockRun     <= 1'b0;
			linkClocksRun      <= 1'b0;
		end else begin
			if (wrDone) begin
				regWrValid <= 1'b0;
			end
			case (state)
			S_OFF: begin
				if (cmdStart) begin
					// RULE1 reset low time
					powerDownResetPinN <= 1'b0;
					cnt                <= RESET_CYC - 32'h1;
					state              <= S_RST;
				end
			end
			S_RST: begin
				if (cnt == 32'h0) begin
					powerDownResetPinN <= 1'b1;
					cnt                <= SETTLE_CYC - 32'h1;
					state              <= S_SETTLE;
				end else begin
					cnt <= cnt - 32'h1;
				end
			end
			S_SETTLE: begin
				// RULE2 no writes here
				if (cnt == 32'h0) begin
					idx    <= {(`CPS_TBL_AW+1){1'b0}};
					rdPend <= 1'b0;
					clkUp  <= 1'b0;
					// RULE22 clock before blocks power
					masterClockRun <= (clockMode != `CPS_MODE_PLL_SLAVE);
					state          <= S_CFG;
				end else begin
					cnt <= cnt - 32'h1;
				end
			end
			S_CFG: begin
				// RULE11 RULE13 table stream
				// RULE14 RULE15 coefficients first
				if (rdPend) begin
					rdPend     <= 1'b0;
					regWrAddr  <= tblWord[15:8];
					regWrData  <= tblWord[7:0];
					regWrValid <= 1'b1;
					idx        <= idx + {{`CPS_TBL_AW{1'b0}}, 1'b1};
				end else if (!regWrValid) begin
					if (idx != tblCount) begin
						rdPend <= 1'b1;
					end else if (clkUp) begin
						// RULE10 relock after rate change
						if (isPll(clockMode)) begin
							cnt   <= lockCyc - 32'h1;
							state <= S_LOCK;
						end else begin
							state <= S_READY;
						end
					end else begin
						case (clockMode)
						`CPS_MODE_PLL_MASTER, `CPS_MODE_PLL_SLAVE: begin
							// RULE3 fields before enables
							regWrAddr  <= `CPS_ADDR_CLOCK;
							regWrData  <= CLK_OSC_PLL;
							regWrValid <= 1'b1;
							state      <= S_CLKW;
						end
						`CPS_MODE_EXT_SLAVE: begin
							// RULE8 link clocks after fields; master clock runs since settle
							linkClocksRun <= 1'b1;
							clkUp         <= 1'b1;
							state         <= S_READY;
						end
						default: begin
							cnt   <= OSC_CYC - 32'h1;
							state <= S_PRE;
						end
						endcase
					end
				end
			end
			S_PRE: begin
				// RULE9 master select after oscillator wait
				if (cnt == 32'h0) begin
					regWrAddr  <= `CPS_ADDR_CLOCK;
					regWrData  <= CLK_MASTER;
					regWrValid <= 1'b1;
					state      <= S_CLKW;
				end else begin
					cnt <= cnt - 32'h1;
				end
			end
			S_CLKW: begin
				if (wrDone) begin
					clkUp <= 1'b1;
					if (isPll(clockMode)) begin
						// RULE7 reference after fields
						if (clockMode == `CPS_MODE_PLL_SLAVE) begin
							linkClocksRun <= 1'b1;
						end
						// RULE4 lock wait
						cnt   <= lockCyc - 32'h1;
						state <= S_LOCK;
					end else begin
						state <= S_READY;
					end
				end
			end
			S_LOCK: begin
				// RULE5 RULE6 use after lock only
				if (cnt == 32'h0) begin
					state <= S_READY;
				end else begin
					cnt <= cnt - 32'h1;
				end
			end
			S_READY: begin
				if (cmdPowerUp) begin
					// RULE16 four bits together
					regWrAddr  <= `CPS_ADDR_POWER;
					regWrData  <= PWR_ALL;
					regWrValid <= 1'b1;
					pwrOn      <= 1'b1;
					state      <= S_PWRW;
				end else if (cmdReconfig) begin
					idx   <= {(`CPS_TBL_AW+1){1'b0}};
					state <= S_CFG;
				end else if (cmdStop) begin
					if (clockMode == `CPS_MODE_EXT_SLAVE) begin
						masterClockRun     <= 1'b0;
						linkClocksRun      <= 1'b0;
						// RULE21 registers back to defaults
						powerDownResetPinN <= 1'b0;
						state              <= S_OFF;
					end else begin
						// RULE18 RULE19 enables cleared first
						regWrAddr  <= `CPS_ADDR_CLOCK;
						regWrData  <= ZERO_BYTE;
						regWrValid <= 1'b1;
						state      <= S_STOPW;
					end
				end
			end
			S_PWRW: begin
				if (wrDone) begin
					if (pwrOn) begin
						cnt   <= LIMIT_CYC - 32'h1;
						state <= S_LIMIT;
					end else begin
						state <= S_READY;
					end
				end
			end
			S_LIMIT, S_RUN: begin
				if (cmdPowerDown) begin
					// RULE16 four bits cleared together
					regWrAddr  <= `CPS_ADDR_POWER;
					regWrData  <= ZERO_BYTE;
					regWrValid <= 1'b1;
					pwrOn      <= 1'b0;
					state      <= S_PWRW;
				end else if (state == S_LIMIT) begin
					// RULE17 limiter start-up wait
					if (cnt == 32'h0) begin
						state <= S_RUN;
					end else begin
						cnt <= cnt - 32'h1;
					end
				end
			end
			S_STOPW: begin
				if (wrDone) begin
					// RULE18 RULE19 clocks stop after write
					masterClockRun     <= 1'b0;
					linkClocksRun      <= 1'b0;
					// RULE21 registers back to defaults
					powerDownResetPinN <= 1'b0;
					clkUp              <= 1'b0;
					state              <= S_OFF;
				end
			end
			default: begin
				state <= S_OFF;
			end
			endcase
		end
	end

endmodule // cps_sequencer
`default_nettype wire

// >>> sim/cps_codec_model.sv
// behavioural codec model behind the sequencer's control-port write requests
`timescale 1ns/1ns
`default_nettype none
module cps_codec_model #(
	parameter int SETTLE = 10,
	parameter int LOCK_F = 50,
	parameter int LOCK_B = 30
) (
	// device pins
	input  wire logic       sys_clk,
	input  wire logic       resetPinN,
	input  wire logic       frameRef,
	input  wire logic       slow,
	// control port
	input  wire logic       regWrValid,
	input  wire logic [7:0] regWrAddr,
	input  wire logic [7:0] regWrData,
	output var  logic       regWrReady,
	// observation
	output wire logic       locked,
	output var  logic [7:0] errCnt
);
	logic [7:0]  regs [0:127];
	logic [31:0] upCnt = 0;
	logic [31:0] lockCnt = 0;
	logic [2:0]  dly = 3'h0;
	initial errCnt = 8'h00;
	initial regWrReady = 1'b0;
	// frame and bit clocks driven only while master-select holds, else parked
	wire logic driveClk = resetPinN && regs[1][3];
	// lock within its bound once the pll bit is on
	assign locked = regs[1][1] && lockCnt == (frameRef ? LOCK_F : LOCK_B);
	always @(posedge sys_clk) begin
		if (!resetPinN) begin
			for (int i = 0; i < 128; i++) regs[i] <= 8'h00;
		end
		upCnt <= resetPinN ? upCnt + 1 : 0;
		lockCnt <= !regs[1][1] ? 0 : locked ? lockCnt : lockCnt + 1;
		regWrReady <= 1'b0;
		if (regWrValid && !regWrReady) begin
			dly <= dly + 3'h1;
			if (!slow || dly == 3'h4) begin
				regWrReady <= 1'b1;
				dly <= 3'h0;
				regs[regWrAddr[6:0]] <= regWrData;
				// writes while in reset or while the reference powers up are stored but counted as errors
				if (!resetPinN || upCnt < SETTLE) errCnt <= errCnt + 8'h01;
			end
		end
	end
endmodule // cps_codec_model
`default_nettype wire

// >>> sim/cps_seq_monitor.sv
// assertion checker for the sequencer's write port, pins and status
`timescale 1ns/1ns
`default_nettype none
`include "cps_regs.vh"
module cps_seq_monitor #(
	parameter [31:0] RESET_CYC = 20, SETTLE_CYC = 10, LOCK_M_CYC = 30,
	parameter [31:0] LOCK_F_CYC = 50, LOCK_B_CYC = 30, OSC_CYC = 8, LIMIT_CYC = 40
) (
	// clock and reset
	input wire logic       sys_clk,
	input wire logic       srst,
	// configuration
	input wire logic [1:0] clockMode,
	input wire logic       pllRefIsFrame,
	// device write port
	input wire logic       regWrValid,
	input wire logic [7:0] regWrAddr,
	input wire logic [7:0] regWrData,
	input wire logic       regWrReady,
	// pins and status
	input wire logic       powerDownResetPinN,
	input wire logic       masterClockRun,
	input wire logic       linkClocksRun,
	input wire logic       statusClockReady,
	input wire logic       statusRunning
);
	logic [31:0] lowCnt, hiCnt, clkCnt, limCnt, mclkCnt;
	logic        pwrOn;
	wire logic acc = regWrValid && regWrReady;
	wire logic clkAcc = acc && regWrAddr == `CPS_ADDR_CLOCK;
	wire logic stopAcc = clkAcc && regWrData == 8'h00;
	wire logic pwrUp = acc && regWrAddr == `CPS_ADDR_POWER && regWrData == 8'h0F;
	wire logic pwrDn = acc && regWrAddr == `CPS_ADDR_POWER && regWrData == 8'h00;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	always @(posedge sys_clk) begin
		lowCnt <= (srst || powerDownResetPinN) ? 32'h0 : lowCnt + 32'h1;
		hiCnt <= (srst || !powerDownResetPinN) ? 32'h0 : hiCnt + 32'h1;
		clkCnt <= srst ? 32'h0 : clkAcc ? 32'h1 : clkCnt + 32'h1;
		limCnt <= srst ? 32'h0 : pwrUp ? 32'h1 : limCnt + 32'h1;
		mclkCnt <= (srst || !masterClockRun) ? 32'h0 : mclkCnt + 32'h1;
		pwrOn <= !srst && (pwrUp || (pwrOn && !pwrDn));
	end
	sequence sStall;
		regWrValid && !regWrReady;
	endsequence
	sequence sHeld;
		regWrValid && $stable(regWrAddr) && $stable(regWrData);
	endsequence
	a_write_holds: assert property (sStall |=> sHeld)
		else $error("write request changed before acceptance");
	a_reset_long: assert property ($rose(powerDownResetPinN) |-> lowCnt >= RESET_CYC)
		else $error("reset pin released too early");
	a_settle_quiet: assert property (regWrValid |-> hiCnt >= SETTLE_CYC)
		else $error("register write during settling");
	a_master_lock: assert property ($rose(statusClockReady) && clockMode == 2'h0
		|-> clkCnt >= LOCK_M_CYC) else $error("master lock wait too short");
	a_slave_lock: assert property ($rose(statusClockReady) && clockMode == 2'h1
		|-> clkCnt >= (pllRefIsFrame ? LOCK_F_CYC : LOCK_B_CYC))
		else $error("slave lock wait too short");
	a_osc_first: assert property (regWrValid && regWrAddr == `CPS_ADDR_CLOCK
		&& regWrData[3] |-> mclkCnt >= OSC_CYC) else $error("master select too early");
	a_power_group: assert property (regWrValid && regWrAddr == `CPS_ADDR_POWER
		|-> regWrData inside {8'h00, 8'h0F}) else $error("power bits not set together");
	a_limit_wait: assert property ($rose(statusRunning) |-> limCnt >= LIMIT_CYC)
		else $error("running reported too early");
	a_stop_order: assert property ($fell(masterClockRun) && clockMode != 2'h2
		|-> $past(stopAcc)) else $error("master clock stopped before clock bits cleared");
	a_clocks_on: assert property (pwrOn |-> masterClockRun || linkClocksRun)
		else $error("blocks powered without clocks");
	a_ref_after: assert property ($rose(linkClocksRun) && clockMode == 2'h1
		|-> $past(clkAcc)) else $error("reference clock supplied before clock bits written");
	a_slave_stop: assert property ($fell(linkClocksRun) && clockMode == 2'h1
		|-> $past(stopAcc)) else $error("link clocks stopped before pll bit cleared");
endmodule // cps_seq_monitor
bind cps_sequencer cps_seq_monitor #(.RESET_CYC(RESET_CYC), .SETTLE_CYC(SETTLE_CYC),
	.LOCK_M_CYC(LOCK_M_CYC), .LOCK_F_CYC(LOCK_F_CYC), .LOCK_B_CYC(LOCK_B_CYC),
	.OSC_CYC(OSC_CYC), .LIMIT_CYC(LIMIT_CYC)) mon_u (.sys_clk(sys_clk), .srst(srst),
	.clockMode(clockMode), .pllRefIsFrame(pllRefIsFrame), .regWrValid(regWrValid),
	.regWrAddr(regWrAddr), .regWrData(regWrData), .regWrReady(regWrReady),
	.powerDownResetPinN(powerDownResetPinN), .masterClockRun(masterClockRun),
	.linkClocksRun(linkClocksRun), .statusClockReady(statusClockReady),
	.statusRunning(statusRunning));
`default_nettype wire

// >>> sim/cps_sequencer_bench.sv
// self-checking bench for the codec clock and power sequencer
`timescale 1ns/1ns
`default_nettype none
module cps_sequencer_bench;
	logic       sys_clk = 1'b0;
	logic       srst = 1'b1;
	logic       slow = 1'b0;
	logic       pllRefIsFrame = 1'b0;
	logic       tblWrEn = 1'b0;
	logic [4:0] cmd = 5'h00;
	logic [1:0] clockMode = 2'h0;
	logic [6:0] tblWrIdx = 7'h00;
	// shortened waits: reset, settle, the three locks, oscillator, limiter start-up
	localparam int T_RST = 20;
	localparam int T_SET = 10;
	localparam int T_LKM = 30;
	localparam int T_LKF = 50;
	localparam int T_LKB = 30;
	localparam int T_OSC = 8;
	localparam int T_LIM = 40;
	logic [7:0] tA [4] = '{8'h05, 8'h08, 8'h0E, 8'h7D};
	// per pass: clock register, {master, link} clocks, extra wait; pass 4 is pll slave on bit clock
	logic [7:0] cr [5] = '{8'h03, 8'h03, 8'h00, 8'h09, 8'h03};
	logic [1:0] mc [5] = '{2'h2, 2'h1, 2'h3, 2'h2, 2'h1};
	int         lk [5] = '{T_LKM, T_LKF, 0, T_OSC, T_LKB};
	logic [7:0] tblCnt = 8'h04;
	int         failCount = 0;
	int         checksDone = 0;
	int         cyc;
	wire logic [7:0] tblWrAddr = tA[tblWrIdx[1:0]];
	wire logic [7:0] tblWrData = tblWrAddr ^ 8'hA5;
	wire logic [7:0] regWrAddr, regWrData, devErr;
	wire logic       regWrValid, regWrReady, pinN, mclk, link, locked;
	wire logic [3:0] st;
	always #5 sys_clk = ~sys_clk;
	cps_sequencer #(.RESET_CYC(T_RST), .SETTLE_CYC(T_SET), .LOCK_M_CYC(T_LKM),
		.LOCK_F_CYC(T_LKF), .LOCK_B_CYC(T_LKB), .OSC_CYC(T_OSC), .LIMIT_CYC(T_LIM))
		dut_u (.sys_clk(sys_clk), .srst(srst),
		.cmdStart(cmd[0]), .cmdReconfig(cmd[1]), .cmdPowerUp(cmd[2]), .cmdPowerDown(cmd[3]),
		.cmdStop(cmd[4]), .clockMode(clockMode), .pllRefIsFrame(pllRefIsFrame),
		.tblCount(tblCnt), .tblWrEn(tblWrEn), .tblWrIdx(tblWrIdx), .tblWrAddr(tblWrAddr),
		.tblWrData(tblWrData), .regWrValid(regWrValid), .regWrAddr(regWrAddr),
		.regWrData(regWrData), .regWrReady(regWrReady), .powerDownResetPinN(pinN),
		.masterClockRun(mclk), .linkClocksRun(link), .statusOff(st[0]),
		.statusClockReady(st[1]), .statusRunning(st[2]), .statusBusy(st[3]));
	cps_codec_model dev_u (.sys_clk(sys_clk), .resetPinN(pinN), .frameRef(pllRefIsFrame),
		.slow(slow), .regWrValid(regWrValid), .regWrAddr(regWrAddr), .regWrData(regWrData),
		.regWrReady(regWrReady), .locked(locked), .errCnt(devErr));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp) begin
			failCount++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic pulse(input int k);
		@(negedge sys_clk) cmd = 5'h01 << k;
		@(negedge sys_clk) cmd = 5'h00;
	endtask
	task automatic waitSt(input int b);
		cyc = 0;
		while (st[b] !== 1'b1 && cyc < 3000) begin
			@(negedge sys_clk);
			cyc++;
		end
		check(st[b], 1);
	endtask
	task finalReport;
		$display("comparisons %0d, mismatches %0d", checksDone, failCount);
		if (failCount == 0 && checksDone > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge sys_clk);
		failCount++;
		finalReport;
	end
	initial begin
		repeat (6) @(negedge sys_clk);
		srst = 1'b0;
		check({pinN, mclk, link, st}, 7'h01);
		for (int i = 0; i < 4; i++) begin
			@(negedge sys_clk) tblWrEn = 1'b1;
			tblWrIdx = i[6:0];
		end
		@(negedge sys_clk) tblWrEn = 1'b0;
		pulse(2);
		check(st, 4'h1);
		for (int m = 0; m < 5; m++) begin
			clockMode = (m == 4) ? 2'h1 : m[1:0];
			slow = m[0];
			pllRefIsFrame = (m == 1);
			tblCnt = (m == 4) ? 8'h03 : 8'h04;
			pulse(0);
			check(st, 4'h8);
			waitSt(1);
			check(cyc >= T_RST + T_SET + lk[m], 1);
			check(locked, clockMode < 2'h2);
			check(dev_u.regs[1], cr[m]);
			check({mclk, link}, mc[m]);
			check(dev_u.driveClk, m == 3);
			for (int i = 0; i < 4; i++) begin
				check(dev_u.regs[tA[i]], (i < tblCnt) ? (tA[i] ^ 8'hA5) : 8'h00);
			end
			if (m == 0) begin
				pulse(1);
				waitSt(1);
				check(cyc >= T_LKM, 1);
			end
			pulse(2);
			waitSt(2);
			check(cyc >= T_LIM, 1);
			check(dev_u.regs[0], 8'h0F);
			pulse(3);
			waitSt(1);
			check(dev_u.regs[0], 8'h00);
			pulse(4);
			waitSt(0);
			check({pinN, mclk, link}, 3'h0);
			@(negedge sys_clk);
			check(dev_u.regs[5], 8'h00);
			check(dev_u.driveClk, 1'b0);
		end
		check(devErr, 8'h00);
		finalReport;
	end
endmodule // cps_sequencer_bench
`default_nettype wire
